// ---- core/gir_pkg.sv ----
package gir_pkg;

    // Host register select codes, as {select0, select1, select2}.
    localparam logic [2:0] SEL_STATUS_ZERO   = 3'h0;
    localparam logic [2:0] SEL_STATUS_ONE    = 3'h1;
    localparam logic [2:0] SEL_ADDRESS_VIEW  = 3'h2;
    localparam logic [2:0] SEL_MASK_ZERO     = 3'h0;
    localparam logic [2:0] SEL_MASK_ONE      = 3'h1;
    localparam logic [2:0] SEL_AUX_COMMAND   = 3'h3;
    localparam logic [2:0] SEL_ADDRESS_SET   = 3'h4;

    // Status register zero layout; the two summary bits sit on top.
    localparam int ST0_SUMMARY_ZERO = 7;
    localparam int ST0_SUMMARY_ONE  = 6;
    localparam int ST0_BYTE_IN      = 5;
    localparam int ST0_BYTE_OUT     = 4;
    localparam int ST0_END          = 3;
    localparam int ST0_SERIAL_POLL  = 2;
    localparam int ST0_REMOTE_CHG   = 1;
    localparam int ST0_MY_ADDR_CHG  = 0;

    // Status register one layout.
    localparam int ST1_TRIGGER      = 7;
    localparam int ST1_HANDSHAKE    = 6;
    localparam int ST1_UNKNOWN_CMD  = 5;
    localparam int ST1_SECONDARY    = 4;
    localparam int ST1_DEVICE_CLEAR = 3;
    localparam int ST1_MY_ADDRESS   = 2;
    localparam int ST1_SERVICE_REQ  = 1;
    localparam int ST1_IFC          = 0;

    // Events of status one that hold off the accept handshake when unmasked.
    localparam logic [7:0] HOLDOFF_EVENTS = 8'hFC;

    // Address status view layout.
    localparam int AV_REMOTE        = 7;
    localparam int AV_LOCKOUT       = 6;
    localparam int AV_ATTENTION     = 5;
    localparam int AV_LISTEN_PRIM   = 4;
    localparam int AV_TALK_PRIM     = 3;
    localparam int AV_LISTEN_ADDR   = 2;
    localparam int AV_TALK_ADDR     = 1;
    localparam int AV_LAST_LSB      = 0;

    // Address setting layout.
    localparam int AS_DUAL_ENABLE   = 7;
    localparam int AS_LISTEN_OFF    = 6;
    localparam int AS_TALK_OFF      = 5;
    localparam int AS_ADDR_MSB      = 4;

    // Auxiliary command byte layout.
    localparam int AUX_CS_BIT       = 7;
    localparam int AUX_FUNC_W       = 5;
    localparam int AUX_COUNT        = 23;

    localparam logic [4:0] AUX_CHIP_RESET     = 5'h00;
    localparam logic [4:0] AUX_RELEASE_ACCEPT = 5'h01;
    localparam logic [4:0] AUX_FORCE_TRIGGER  = 5'h06;
    localparam logic [4:0] AUX_RETURN_LOCAL   = 5'h07;
    localparam logic [4:0] AUX_DISABLE_INT    = 5'h13;
    localparam logic [4:0] AUX_PASS_SECONDARY = 5'h14;
    localparam logic [4:0] AUX_LAST_CODE      = 5'h16;

    // One bit per code that keeps clear/set state; the rest are pulses.
    localparam logic [AUX_COUNT-1:0] AUX_CS_CAPABLE = 23'h69C6D9;
    // Hardware reset leaves the chip reset command active.
    localparam logic [AUX_COUNT-1:0] AUX_MODE_RESET = 23'h000001;

    // Trigger pulse for a pulsed force-trigger command.
    localparam int CLOCK_PERIOD_PS  = 8000;
    localparam int TRIG_PULSE_US    = 1;
    localparam int TRIG_CYCLES      = TRIG_PULSE_US * 1000000 / CLOCK_PERIOD_PS;
    localparam int TRIG_CNT_W       = 8;

    localparam logic [7:0] BYTE_ZERO = 8'h00;

endpackage

// ---- core/gir_registers.sv ----
`timescale 1ns/1ps
// Behaviour
// - Event bits in both status registers set on their event, whatever the mask.
// - Each summary bit is the OR of status bits ANDed with their masks.
// - Reading a status register clears it.
// - Interrupt line is the NOR of both summaries unless disable interrupt is set; summaries clear by reads and by chip reset.
// - Hardware reset and chip reset command clear both status registers.
// - Byte in, byte out, end and remote/local change events have fixed meaning.
// - Unknown command also flags secondaries under pass-through; secondary address flag.
// - Serial poll event needs request bit; service request needs controller in charge.
// - Masks keep their value until rewritten; only unmasked events raise the line.
// - Unmasked holdoff events hold the accept handshake until release command.
// - Address view shows remote, lockout, attention, addressed states, last LSB.
// - Address view is sampled live at each read, not stored.
// - Address setting holds five address bits plus dual, listen and talk disables.
// - Dual addressing makes the comparator ignore the address LSB.
// - Talk disable blocks talker match; listen disable blocks listener match.
// - Command byte: clear/set flag on top, five-bit function code, 23 codes.
// - Clear/set commands set with flag one and stay until written with zero.
// - Pulse-only commands give a one-cycle pulse per write and keep no state.
// - Force trigger pulses with flag zero, holds high with flag one.
// - Return local clears remote; with flag one blocks remote until cleared.
// - Under local lockout return local does nothing.
// - Three select lines and active-low chip enable; reads and writes differ.
module gir_registers #(
    parameter int TRIG_PULSE_CYCLES = gir_pkg::TRIG_CYCLES
) (
    input  wire logic                           clock,
    input  wire logic                           rst,
    input  wire logic                           host_ce_n,
    input  wire logic                           host_we_n,
    input  wire logic                           host_dbin,
    input  wire logic [2:0]                     host_rs,
    input  wire logic [7:0]                     host_data_in,
    output logic      [7:0]                     host_data_out,
    output logic                                host_data_oe,
    output logic                                int_n,
    input  wire logic                           ev_byte_in,
    input  wire logic                           ev_byte_out,
    input  wire logic                           ev_end,
    input  wire logic                           ev_serial_poll,
    input  wire logic                           request_service_bit,
    input  wire logic                           ev_my_address_change,
    input  wire logic                           ev_trigger,
    input  wire logic                           ev_handshake_error,
    input  wire logic                           ev_unknown_cmd,
    input  wire logic                           ev_secondary_cmd,
    input  wire logic                           ev_secondary_addr,
    input  wire logic                           ev_device_clear,
    input  wire logic                           ev_my_address,
    input  wire logic                           ev_service_request,
    input  wire logic                           controller_in_charge,
    input  wire logic                           ev_interface_clear,
    input  wire logic                           remote_enable,
    input  wire logic                           local_lockout,
    input  wire logic                           attention,
    input  wire logic                           listen_primary,
    input  wire logic                           talk_primary,
    input  wire logic                           listen_addressed,
    input  wire logic                           talk_addressed,
    input  wire logic                           last_address_lsb,
    input  wire logic                           compare_valid,
    input  wire logic                           compare_talk,
    input  wire logic [gir_pkg::AUX_FUNC_W-1:0] compare_address,
    output logic                                listen_match,
    output logic                                talk_match,
    output logic                                far_control_bit,
    output logic                                accept_holdoff,
    output logic                                trigger_out,
    output logic                                pass_next_secondary,
    output logic [7:0]                          address_setting,
    output logic [gir_pkg::AUX_COUNT-1:0]       aux_mode,
    output logic [gir_pkg::AUX_COUNT-1:0]       aux_pulse
);
    import gir_pkg::*;

    if (TRIG_PULSE_CYCLES < 1 || TRIG_PULSE_CYCLES >= (1 << TRIG_CNT_W)) begin : g_trig_check
        $error("TRIG_PULSE_CYCLES out of range");
    end

    localparam logic [TRIG_CNT_W-1:0] TRIG_LOAD = TRIG_CNT_W'(TRIG_PULSE_CYCLES);

    typedef struct packed {
        logic                  ce_n_meta;
        logic                  ce_n_sync;
        logic                  we_n_meta;
        logic                  we_n_sync;
        logic                  dbin_meta;
        logic                  dbin_sync;
        logic [2:0]            rs_meta;
        logic [2:0]            rs_sync;
        logic [7:0]            din_meta;
        logic [7:0]            din_sync;
        logic                  read_prev;
        logic                  write_prev;
        logic [5:0]            status_zero;
        logic [7:0]            status_one;
        logic [5:0]            mask_zero;
        logic [7:0]            mask_one;
        logic [7:0]            address_setting;
        logic [AUX_COUNT-1:0]  aux_mode;
        logic [AUX_COUNT-1:0]  aux_pulse;
        logic [TRIG_CNT_W-1:0] trig_count;
        logic                  trigger_out;
        logic                  far_control;
        logic                  pass_next;
        logic                  accept_holdoff;
        logic                  int_n;
        logic [7:0]            data_out;
        logic                  data_oe;
        logic                  listen_match;
        logic                  talk_match;
    } gir_state_t;

    localparam gir_state_t STATE_RESET = '{
        ce_n_meta:   1'b1,
        ce_n_sync:   1'b1,
        we_n_meta:   1'b1,
        we_n_sync:   1'b1,
        int_n:       1'b1,
        aux_mode:    AUX_MODE_RESET,
        default:     '0
    };

    gir_state_t state;
    gir_state_t next_state;

    always_comb begin
        logic                  read_now;
        logic                  write_now;
        logic                  read_start;
        logic                  write_start;
        logic                  chip_idle;
        logic                  cs_flag;
        logic [4:0]            func;
        logic [5:0]            set_zero;
        logic [7:0]            set_one;
        logic                  summary_zero;
        logic                  summary_one;
        logic [7:0]            live_view;
        logic [3:0]            addr_diff;
        logic                  addr_hit;
        logic                  rtl_clear;
        logic                  next_remote;

        next_state = state;
        read_now = 1'b0;
        write_now = 1'b0;
        read_start = 1'b0;
        write_start = 1'b0;
        chip_idle = 1'b0;
        cs_flag = 1'b0;
        func = '0;
        set_zero = '0;
        set_one = '0;
        summary_zero = 1'b0;
        summary_one = 1'b0;
        live_view = '0;
        addr_diff = '0;
        addr_hit = 1'b0;
        rtl_clear = 1'b0;
        next_remote = 1'b0;

        // Host pins are asynchronous, so each passes two flops first.
        next_state.ce_n_meta = host_ce_n;
        next_state.ce_n_sync = state.ce_n_meta;
        next_state.we_n_meta = host_we_n;
        next_state.we_n_sync = state.we_n_meta;
        next_state.dbin_meta = host_dbin;
        next_state.dbin_sync = state.dbin_meta;
        next_state.rs_meta   = host_rs;
        next_state.rs_sync   = state.rs_meta;
        next_state.din_meta  = host_data_in;
        next_state.din_sync  = state.din_meta;

        // A read and a write to one select code reach different registers.
        read_now  = !state.ce_n_sync && state.dbin_sync && state.we_n_sync;
        write_now = !state.ce_n_sync && !state.dbin_sync && !state.we_n_sync;
        read_start  = read_now && !state.read_prev;
        write_start = write_now && !state.write_prev;
        next_state.read_prev  = read_now;
        next_state.write_prev = write_now;

        cs_flag = state.din_sync[AUX_CS_BIT];
        func    = state.din_sync[AUX_FUNC_W-1:0];
        chip_idle = state.aux_mode[AUX_CHIP_RESET];

        // Pulses last exactly one cycle and carry no memory.
        next_state.aux_pulse = '0;

        // Auxiliary command decode.
        if (write_start && state.rs_sync == SEL_AUX_COMMAND && func <= AUX_LAST_CODE) begin
            if (AUX_CS_CAPABLE[func]) begin
                if (func != AUX_RETURN_LOCAL || !local_lockout) begin
                    next_state.aux_mode[func] = cs_flag;
                end
            end else begin
                next_state.aux_pulse[func] = 1'b1;
            end
            if (func == AUX_RETURN_LOCAL && !local_lockout) begin
                rtl_clear = 1'b1;
            end
            if (func == AUX_FORCE_TRIGGER) begin
                next_state.trig_count = cs_flag ? '0 : TRIG_LOAD;
            end
        end else if (state.trig_count != '0) begin
            next_state.trig_count = state.trig_count - 1'b1;
        end
        next_state.trigger_out = next_state.aux_mode[AUX_FORCE_TRIGGER]
                               || (next_state.trig_count != '0);

        // Other write registers.
        if (write_start) begin
            unique case (state.rs_sync)
                SEL_MASK_ZERO:   next_state.mask_zero = state.din_sync[5:0];
                SEL_MASK_ONE:    next_state.mask_one  = state.din_sync;
                SEL_ADDRESS_SET: next_state.address_setting = state.din_sync;
                default: ;
            endcase
        end

        // Remote state: a held return-local blocks remote enable.
        next_remote = state.far_control;
        if (rtl_clear) begin
            next_remote = 1'b0;
        end else if (remote_enable && !next_state.aux_mode[AUX_RETURN_LOCAL]) begin
            next_remote = 1'b1;
        end
        next_state.far_control = next_remote;

        // Pass-through of the next secondary command.
        if (next_state.aux_pulse[AUX_PASS_SECONDARY]) begin
            next_state.pass_next = 1'b1;
        end else if (ev_secondary_cmd) begin
            next_state.pass_next = 1'b0;
        end

        // Events are sampled regardless of mask; the chip reset keeps them out.
        set_zero[ST0_BYTE_IN]     = ev_byte_in;
        set_zero[ST0_BYTE_OUT]    = ev_byte_out;
        set_zero[ST0_END]         = ev_end;
        set_zero[ST0_SERIAL_POLL] = ev_serial_poll && request_service_bit;
        set_zero[ST0_REMOTE_CHG]  = next_remote != state.far_control;
        set_zero[ST0_MY_ADDR_CHG] = ev_my_address_change;
        set_one[ST1_TRIGGER]      = ev_trigger;
        set_one[ST1_HANDSHAKE]    = ev_handshake_error;
        set_one[ST1_UNKNOWN_CMD]  = ev_unknown_cmd
                                  || (ev_secondary_cmd && state.pass_next);
        set_one[ST1_SECONDARY]    = ev_secondary_addr;
        set_one[ST1_DEVICE_CLEAR] = ev_device_clear;
        set_one[ST1_MY_ADDRESS]   = ev_my_address;
        set_one[ST1_SERVICE_REQ]  = ev_service_request && controller_in_charge;
        set_one[ST1_IFC]          = ev_interface_clear;

        // Live address view, captured at the moment of the read.
        live_view[AV_REMOTE]      = state.far_control;
        live_view[AV_LOCKOUT]     = local_lockout;
        live_view[AV_ATTENTION]   = attention;
        live_view[AV_LISTEN_PRIM] = listen_primary;
        live_view[AV_TALK_PRIM]   = talk_primary;
        live_view[AV_LISTEN_ADDR] = listen_addressed;
        live_view[AV_TALK_ADDR]   = talk_addressed;
        live_view[AV_LAST_LSB]    = last_address_lsb;

        summary_zero = |(state.status_zero & state.mask_zero);
        summary_one  = |(state.status_one & state.mask_one);

        // Read path; a status read clears the register but a same-cycle event survives.
        if (read_start) begin
            next_state.data_oe = 1'b1;
            unique case (state.rs_sync)
                SEL_STATUS_ZERO: begin
                    next_state.data_out = {summary_zero, summary_one, state.status_zero};
                    next_state.status_zero = '0;
                end
                SEL_STATUS_ONE: begin
                    next_state.data_out = state.status_one;
                    next_state.status_one = '0;
                end
                SEL_ADDRESS_VIEW: next_state.data_out = live_view;
                default:          next_state.data_out = BYTE_ZERO;
            endcase
        end else if (!read_now) begin
            next_state.data_oe = 1'b0;
        end

        if (chip_idle) begin
            next_state.status_zero = '0;
            next_state.status_one  = '0;
        end else begin
            next_state.status_zero = next_state.status_zero | set_zero;
            next_state.status_one  = next_state.status_one | set_one;
        end

        // Unmasked holdoff events stall the handshake until the release pulse.
        if (chip_idle) begin
            next_state.accept_holdoff = 1'b0;
        end else if (|(set_one & state.mask_one & HOLDOFF_EVENTS)) begin
            next_state.accept_holdoff = 1'b1;
        end else if (next_state.aux_pulse[AUX_RELEASE_ACCEPT]) begin
            next_state.accept_holdoff = 1'b0;
        end

        // The line follows the new status so it falls on the same edge as the bits set.
        next_state.int_n = next_state.aux_mode[AUX_DISABLE_INT]
                         || !(|(next_state.status_zero & next_state.mask_zero)
                              || |(next_state.status_one & next_state.mask_one));

        // Address comparator.
        addr_diff = compare_address[4:1] ^ state.address_setting[AS_ADDR_MSB:1];
        addr_hit  = (addr_diff == '0)
                  && (state.address_setting[AS_DUAL_ENABLE]
                      || compare_address[0] == state.address_setting[0]);
        next_state.listen_match = compare_valid && !compare_talk && addr_hit
                                && !state.address_setting[AS_LISTEN_OFF];
        next_state.talk_match   = compare_valid && compare_talk && addr_hit
                                && !state.address_setting[AS_TALK_OFF];
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= STATE_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign host_data_out       = state.data_out;
    assign host_data_oe        = state.data_oe;
    assign int_n               = state.int_n;
    assign listen_match        = state.listen_match;
    assign talk_match          = state.talk_match;
    assign far_control_bit     = state.far_control;
    assign accept_holdoff      = state.accept_holdoff;
    assign trigger_out         = state.trigger_out;
    assign pass_next_secondary = state.pass_next;
    assign address_setting     = state.address_setting;
    assign aux_mode            = state.aux_mode;
    assign aux_pulse           = state.aux_pulse;

endmodule

// ---- dv/gir_registers_properties.sv ----
`timescale 1ns/1ps
module gir_registers_properties
    import gir_pkg::*;
#(
    parameter int TRIG_PULSE_CYCLES = 4
) (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        compare_valid,
    input wire logic        compare_talk,
    input wire logic [4:0]  compare_address,
    input wire logic        listen_match,
    input wire logic        talk_match,
    input wire logic        accept_holdoff,
    input wire logic        trigger_out,
    input wire logic        int_n,
    input wire logic [7:0]  address_setting,
    input wire logic [22:0] aux_mode,
    input wire logic [22:0] aux_pulse
);
    import gir_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    chk_trig_hold: assert property (
        aux_mode[AUX_FORCE_TRIGGER] && $past(aux_mode[AUX_FORCE_TRIGGER]) |-> trigger_out)
        else $error("trigger dropped while held");
    chk_pulse_nostate: assert property (
        (aux_pulse & AUX_CS_CAPABLE) == 23'h000000) else $error("pulse on a held code");
    chk_pulse_single: assert property (
        aux_pulse != 23'h000000 |=> aux_pulse == 23'h000000) else $error("pulse too long");
    chk_mode_split: assert property (
        (aux_mode & ~AUX_CS_CAPABLE) == 23'h000000) else $error("mode kept by pulse code");
    chk_int_off: assert property (
        aux_mode[AUX_DISABLE_INT] && $past(aux_mode[AUX_DISABLE_INT]) |-> int_n)
        else $error("interrupt not disabled");
    chk_idle_holdoff: assert property (
        aux_mode[AUX_CHIP_RESET] |=> !accept_holdoff) else $error("holdoff while idle");
    chk_talk_off: assert property (
        compare_valid && compare_talk && address_setting[AS_TALK_OFF] |=> !talk_match)
        else $error("talk match while talk disabled");
    chk_listen_off: assert property (
        compare_valid && !compare_talk && address_setting[AS_LISTEN_OFF] |=> !listen_match)
        else $error("listen match while listen disabled");
    chk_dual_match: assert property (
        compare_valid && !compare_talk && address_setting[7:6] == 2'h2 && !aux_mode[0]
        && compare_address[4:1] == address_setting[4:1] |=> listen_match)
        else $error("dual address missed");
endmodule
bind gir_registers gir_registers_properties #(.TRIG_PULSE_CYCLES(TRIG_PULSE_CYCLES))
    i_gir_registers_properties (.*);

// ---- dv/gir_bus_model.sv ----
`timescale 1ns/1ps
module gir_bus_model (
    input  wire logic       clock,
    input  wire logic       rst,
    output logic            compare_valid,
    output logic            compare_talk,
    output logic [4:0]      compare_address
);
    logic [7:0] lfsr;
    // The address lines shift one LFSR step every cycle, so they keep moving between offers.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lfsr <= 8'h5A;
            compare_valid <= 1'b0;
        end else begin
            lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
            compare_valid <= lfsr[1:0] == 2'h0;
        end
    end
    assign compare_talk = lfsr[2];
    assign compare_address = lfsr[7:3];
endmodule

// ---- dv/tb_gir_registers.sv ----
`timescale 1ns/1ps
module tb_gir_registers;
    import gir_pkg::*;
    logic        clock = 0, rst = 1, host_ce_n = 1, host_we_n = 1, host_dbin = 0, oe_q = 0;
    logic [2:0]  host_rs = 0;
    logic [7:0]  host_data_in = 0, v, host_data_out, address_setting, q[$];
    logic [14:0] ev = 0;
    logic [8:0]  lv = 0;
    logic [31:0] seed = 32'h369B899C;
    logic [22:0] aux_mode, aux_pulse;
    logic [4:0]  compare_address;
    logic        host_data_oe, int_n, listen_match, talk_match, far_control_bit, accept_holdoff;
    logic        trigger_out, pass_next_secondary, compare_valid, compare_talk;
    int          err_total = 0, checked = 0, cyc = 0, thi = 0, n0;
    int          S0[5] = '{5, 4, 3, 2, 0};
    int          PC[10] = '{2, 5, 8, 11, 12, 13, 17, 18, 20, 23};
    wire ev_byte_in, ev_byte_out, ev_end, ev_serial_poll, ev_my_address_change, ev_trigger,
        ev_handshake_error, ev_unknown_cmd, ev_secondary_addr, ev_device_clear, ev_my_address,
        ev_service_request, ev_interface_clear, ev_secondary_cmd, remote_enable;
    wire request_service_bit, controller_in_charge, local_lockout, attention, listen_primary,
        talk_primary, listen_addressed, talk_addressed, last_address_lsb;
    assign {ev_byte_in, ev_byte_out, ev_end, ev_serial_poll, ev_my_address_change, ev_trigger,
        ev_handshake_error, ev_unknown_cmd, ev_secondary_addr, ev_device_clear, ev_my_address,
        ev_service_request, ev_interface_clear, ev_secondary_cmd, remote_enable} = ev;
    assign {request_service_bit, controller_in_charge, local_lockout, attention, listen_primary,
        talk_primary, listen_addressed, talk_addressed, last_address_lsb} = lv;
    gir_registers #(.TRIG_PULSE_CYCLES(4)) i_gir_registers (.*);
    gir_bus_model i_gir_bus_model (.*);
    initial forever #4 clock = ~clock;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        checked++;
        if (e !== s) begin
            err_total++;
            $display("unexpected %s expected %0h seen %0h", n, e, s);
        end
    endtask
    task automatic conclude();
        chk("pending reads", 0, q.size());
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Strobes stay up until read data shows or the write has surely been taken.
    task automatic acc(logic w, logic [2:0] rs, logic [7:0] d);
        host_rs <= rs;
        host_data_in <= d;
        host_we_n <= !w;
        host_dbin <= !w;
        host_ce_n <= 1'b0;
        for (int i = 0; i < 12 && !(host_data_oe === 1'b1 && !w); i++) @(posedge clock);
        host_ce_n <= 1'b1;
        host_we_n <= 1'b1;
        host_dbin <= 1'b0;
        repeat (6) @(posedge clock);
    endtask
    task automatic rd(logic [2:0] rs, logic [7:0] e);
        q.push_back(e);
        acc(1'b0, rs, 8'h00);
    endtask
    task automatic fire(logic [14:0] b);
        ev <= b;
        @(posedge clock);
        ev <= 15'h0000;
        repeat (3) @(posedge clock);
    endtask
    always @(posedge clock) begin
        thi <= thi + trigger_out;
        if (host_data_oe === 1'b1 && !oe_q) chk("read data", q.pop_front(), host_data_out);
        oe_q <= host_data_oe;
        if (++cyc == 40000) begin
            err_total++;
            conclude();
        end
    end
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        acc(1'b1, SEL_AUX_COMMAND, 8'h00);
        rd(SEL_STATUS_ZERO, 8'h00);
        acc(1'b1, SEL_MASK_ZERO, 8'h3F);
        lv <= 9'h100;
        foreach (S0[k]) begin
            fire(15'h0001 << (S0[k] > 0 ? S0[k] + 9 : 10));
            chk("int_n", 0, int_n);
            rd(SEL_STATUS_ZERO, 8'h80 | (8'h01 << S0[k]));
            rd(SEL_STATUS_ZERO, 8'h00);
            chk("int_n", 1, int_n);
        end
        acc(1'b1, SEL_MASK_ZERO, 8'h00);
        lv <= 9'h000;
        fire(15'h4800);
        chk("int_n", 1, int_n);
        rd(SEL_STATUS_ZERO, 8'h20);
        fire(15'h0008);
        rd(SEL_STATUS_ONE, 8'h00);
        $display("status zero test done");
        acc(1'b1, SEL_MASK_ONE, 8'hFF);
        lv <= 9'h080;
        acc(1'b1, SEL_AUX_COMMAND, 8'h14);
        fire(15'h0002);
        rd(SEL_STATUS_ZERO, 8'h40);
        rd(SEL_STATUS_ONE, 8'h20);
        acc(1'b1, SEL_AUX_COMMAND, 8'h01);
        for (int b = 7; b >= 0; b--) begin
            fire(15'h0001 << (b + 2));
            chk("holdoff", b >= 2, accept_holdoff);
            rd(SEL_STATUS_ONE, 8'h01 << b);
            acc(1'b1, SEL_AUX_COMMAND, 8'h01);
            chk("holdoff", 0, accept_holdoff);
        end
        $display("status one test done");
        repeat (3) begin
            v = 8'(xs());
            lv <= {2'h1, v[6:0]};
            rd(SEL_ADDRESS_VIEW, {1'b0, v[6:0]});
        end
        rd(3'h5, 8'h00);
        lv <= 9'h080;
        fire(15'h0001);
        chk("remote", 1, far_control_bit);
        acc(1'b1, SEL_AUX_COMMAND, 8'h07);
        chk("remote", 0, far_control_bit);
        fire(15'h0001);
        lv <= 9'h0C0;
        acc(1'b1, SEL_AUX_COMMAND, 8'h07);
        chk("remote", 1, far_control_bit);
        lv <= 9'h080;
        acc(1'b1, SEL_AUX_COMMAND, 8'h87);
        fire(15'h0001);
        chk("remote", 0, far_control_bit);
        acc(1'b1, SEL_AUX_COMMAND, 8'h07);
        fire(15'h0001);
        chk("remote", 1, far_control_bit);
        rd(SEL_STATUS_ZERO, 8'h02);
        $display("address view and remote test done");
        n0 = thi;
        acc(1'b1, SEL_AUX_COMMAND, 8'h06);
        chk("trigger pulse", 4, thi - n0);
        acc(1'b1, SEL_AUX_COMMAND, 8'h86);
        chk("trigger", 1, trigger_out);
        acc(1'b1, SEL_AUX_COMMAND, 8'h06);
        chk("trigger", 0, trigger_out);
        acc(1'b1, SEL_AUX_COMMAND, 8'h89);
        acc(1'b1, SEL_AUX_COMMAND, 8'h8A);
        acc(1'b1, SEL_AUX_COMMAND, 8'h0A);
        foreach (PC[k]) acc(1'b1, SEL_AUX_COMMAND, 8'h80 | 8'(PC[k]));
        chk("pass next", 1, pass_next_secondary);
        chk("modes", 23'h000200, aux_mode);
        acc(1'b1, SEL_AUX_COMMAND, 8'h09);
        acc(1'b1, SEL_MASK_ZERO, 8'h20);
        acc(1'b1, SEL_AUX_COMMAND, 8'h93);
        fire(15'h4000);
        chk("int_n", 1, int_n);
        acc(1'b1, SEL_AUX_COMMAND, 8'h13);
        chk("int_n", 0, int_n);
        acc(1'b1, SEL_AUX_COMMAND, 8'h80);
        acc(1'b1, SEL_AUX_COMMAND, 8'h00);
        chk("int_n", 1, int_n);
        rd(SEL_STATUS_ZERO, 8'h00);
        $display("command test done");
        for (int i = 0; i < 4; i++) begin
            v = 8'(xs());
            if (i == 0) v[7:6] = 2'h2;
            acc(1'b1, SEL_ADDRESS_SET, v);
            chk("address", v, address_setting);
            repeat (200) @(posedge clock);
        end
        $display("address test done");
        conclude();
    end
endmodule
